/* File: core/iscg_defs.svh */
// Constants for the serial card host glue: offsets, field positions, reset values.
// Assumes inclusion by bare name from the package and the glue module.
`ifndef ISCG_DEFS_SVH
`define ISCG_DEFS_SVH
// Decoded block and offsets inside it
`define ISCG_BLOCK_WORDS      8
`define ISCG_OFF_A_DATA       3'h0
`define ISCG_OFF_A_CTRL       3'h1
`define ISCG_OFF_B_DATA       3'h2
`define ISCG_OFF_B_CTRL       3'h3
`define ISCG_OFF_CTRL_STATUS  3'h4
// Lowest and highest base, as address bits 9..3
`define ISCG_BASE_MIN         7'h20
`define ISCG_BASE_MAX         7'h7F
// Control/status port fields
`define ISCG_BIT_TERM_RDY_A   0
`define ISCG_BIT_TERM_RDY_B   1
`define ISCG_BIT_DMA_EN       7
`define ISCG_CTRL_RESET       8'h00
// Factory strap values, switch bit high means open (address bit one)
`define ISCG_DEF_BASE_SW      7'h47  // R15
`define ISCG_DEF_IRQ_LINE     4'h8
// Full duplex on channel A: receive request on DMA 3, transmit on DMA 1, software enable
`define ISCG_DEF_DREQ_ROUTE   8'hA6
`define ISCG_DEF_DACK_ROUTE   6'h09
`endif

/* File: core/iscg_pkg.sv */
// Types for the serial card host glue: strap fields, pin bundle, access states.
// Assumes iscg_defs.svh is on the include path.
`include "iscg_defs.svh"
package iscg_pkg;
  // Interrupt route header: line jumpers plus mode jumpers
  typedef struct packed {
    logic       shared;     // Several ports on one line
    logic       dedicated;  // This card alone drives the line
    logic [3:0] line;       // Bit 0 line 2/9, bit 1 line 3, bit 2 line 4, bit 3 line 5
  } iscg_irq_route_t;
  // DMA request route header, one bit per jumper position 1..8
  typedef struct packed {
    logic sw_enable; logic perm_enable; logic full_duplex; logic b_half;
    logic d1_a_only; logic d1_a_or_b;   logic d3_a_only;   logic d3_a_or_b;
  } iscg_dreq_route_t;
  // DMA acknowledge route header, positions 1..6
  typedef struct packed {
    logic single_d1; logic single_d3; logic a_only;
    logic chan_a_dma1_chan_b_dma3;      logic chan_a_dma3_chan_b_dma1;      logic both_ack;
  } iscg_dack_route_t;
  // Everything that arrives from outside the clock domain
  typedef struct packed {
    logic [9:0]       addr;
    logic             ior_n;
    logic             iow_n;
    logic             aen;
    logic [7:0]       data;
    logic [6:0]       base_sw;
    iscg_irq_route_t  irq_rt;
    iscg_dreq_route_t dreq_rt;
    iscg_dack_route_t dack_rt;
    logic             ctl_int;
    logic             req_a;
    logic             dtr_req_a;
    logic             req_b;
    logic             dack1_n;
    logic             dack3_n;
    logic [1:0]       dsr;
  } iscg_pins_t;
  typedef enum logic [2:0] {
    ISCG_IDLE = 3'b001,
    ISCG_RD   = 3'b010,
    ISCG_WR   = 3'b100
  } iscg_state_t;
endpackage

/* File: core/iscg_glue.sv */
// Host bus glue for a two-channel serial adapter: I/O decode, board port,
// interrupt and DMA routing. Assumes all pins are asynchronous to clk and
// that the serial controller's own data path sits directly on the host bus.
//
// Operation
// [R1] Card answers a block of eight I/O addresses set by the base switch.
// [R2] Base lies from 100 to 3F8 hex, eight-aligned; low bits pick the port.
// [R3] Address bits 9..3 compare with switches; closed means zero, open means one.
// [R4] Offsets 0..3: channel A data, A control, B data, B control.
// [R5] Offset 4 selects the board control/status port.
// [R6] Interrupt goes to exactly one of lines 2/9, 3, 4, 5, or none.
// [R7] Dedicated mode drives the line alone; shared mode adds the pull-down.
// [R8] Full duplex: channel A uses DMA 1 and 3 together.
// [R9] Half duplex: one DMA channel, one direction at a time.
// [R10] DMA 3 or 1 goes to channel A only or either; B half-duplex enable.
// [R11] Acknowledge splits CHAN_A_DMA3_CHAN_B_DMA1 or CHAN_A_DMA1_CHAN_B_DMA3; single selector picks A or B.
// [R12] DMA drivers permanent, or follow port bit 7, or stay off.
// [R13] Reset clears the software DMA enable.
// [R14] Permanent enable ignores the software DMA enable bit.
// [R15] Factory straps: base 238, transmit DMA 1, receive DMA 3, line 5.
// [R16] Port write: bit 7 DMA enable, bits 0..1 terminal ready; read gives DSR.
// [R17] Controller select only for offsets 0..3; offsets 5..7 ignored.
// [R18] Host holds address stable and qualified by its strobe.
`timescale 1ns/1ns
`include "iscg_defs.svh"

module iscg_glue (
  input  wire logic                  clk,
  input  wire logic                  reset_n,
  input  wire iscg_pkg::iscg_pins_t  pins,
  output logic                       ctl_cs_n,
  output logic [1:0]                 ctl_port,
  output logic                       ctl_rd_n,
  output logic                       ctl_wr_n,
  output logic [7:0]                 data_out,
  output logic                       data_oe,
  output logic [3:0]                 irq_out,
  output logic [3:0]                 irq_oe,
  output logic                       irq_pulldown,
  output logic                       drq1_out,
  output logic                       drq3_out,
  output logic                       drq_oe,
  output logic                       dack_a_n,
  output logic                       dack_b_n,
  output logic                       term_rdy_a,
  output logic                       term_rdy_b
);
  import iscg_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // Two-flop synchroniser for every pin; only stage two is read by logic
  iscg_pins_t  sync1_q;
  iscg_pins_t  pin_q;
  always_ff @(posedge clk) begin
    sync1_q <= pins;
    pin_q   <= sync1_q;
  end

  //////////////////////////////////////////////////////////////////////////
  // Address decode: block match, valid base range, offset split
  wire logic [6:0] blk_addr  = pin_q.addr[9:3];
  wire logic [2:0] offset    = pin_q.addr[2:0];
  wire logic       base_ok   = (pin_q.base_sw >= `ISCG_BASE_MIN) &&
                               (pin_q.base_sw <= `ISCG_BASE_MAX);          // R2
  wire logic       blk_hit   = base_ok && !pin_q.aen &&
                               (blk_addr == pin_q.base_sw);                // R1 R3
  wire logic       rd_act    = !pin_q.ior_n;                               // R18
  wire logic       wr_act    = !pin_q.iow_n;                               // R18
  wire logic       ctl_sel   = blk_hit && (offset <= `ISCG_OFF_B_CTRL);    // R4 R17
  wire logic       port_sel  = blk_hit && (offset == `ISCG_OFF_CTRL_STATUS); // R5

  //////////////////////////////////////////////////////////////////////////
  // Access tracker: a write to the board port commits once, at strobe entry
  iscg_state_t state_q;
  iscg_state_t state_d;
  always_comb begin
    state_d = state_q;
    case (state_q)
      ISCG_IDLE: begin
        if (rd_act) begin
          state_d = ISCG_RD;
        end else if (wr_act) begin
          state_d = ISCG_WR;
        end
      end
      ISCG_RD: begin
        if (!rd_act) begin
          state_d = ISCG_IDLE;
        end
      end
      ISCG_WR: begin
        if (!wr_act) begin
          state_d = ISCG_IDLE;
        end
      end
      default: state_d = ISCG_IDLE;
    endcase
  end

  // Commit only on entry, so a long strobe cannot re-write the port
  wire logic port_wr = (state_q == ISCG_IDLE) && !rd_act && wr_act && port_sel; // R16

  //////////////////////////////////////////////////////////////////////////
  // Board control/status port; offsets 5..7 fall through unanswered
  logic       dma_en_q;
  logic [1:0] term_rdy_q;
  wire logic [7:0] ctrl_rst = `ISCG_CTRL_RESET;  // Port value after reset, taken bit by bit
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_q    <= ISCG_IDLE;
      dma_en_q   <= ctrl_rst[`ISCG_BIT_DMA_EN];                // R13
      term_rdy_q <= ctrl_rst[`ISCG_BIT_TERM_RDY_B:`ISCG_BIT_TERM_RDY_A];
    end else begin
      state_q <= state_d;
      if (port_wr) begin
        dma_en_q   <= pin_q.data[`ISCG_BIT_DMA_EN];            // R16
        term_rdy_q <= pin_q.data[`ISCG_BIT_TERM_RDY_B:`ISCG_BIT_TERM_RDY_A]; // R16
      end
    end
  end

  // Read data: modem inputs in the two low bits, the rest read as zero
  wire logic [7:0] rd_data = {6'h00, pin_q.dsr};                            // R16
  wire logic       rd_port = rd_act && port_sel;

  //////////////////////////////////////////////////////////////////////////
  // Interrupt route: exactly one line jumper, else the card stays off the bus
  wire logic [3:0] line_j   = pin_q.irq_rt.line;
  wire logic       one_line = (line_j != 4'h0) && ((line_j & (line_j - 4'h1)) == 4'h0); // R6
  wire logic       mode_ded = pin_q.irq_rt.dedicated && !pin_q.irq_rt.shared;
  wire logic       mode_shr = pin_q.irq_rt.shared;
  // Dedicated drives both levels; shared only pulls high and lets the resistor return it
  wire logic [3:0] irq_oe_d  = !one_line ? 4'h0 :
                               mode_ded ? line_j :
                               (mode_shr && pin_q.ctl_int) ? line_j : 4'h0;  // R6 R7
  wire logic [3:0] irq_out_d = pin_q.ctl_int ? line_j : 4'h0;               // R7

  //////////////////////////////////////////////////////////////////////////
  // DMA request routing
  iscg_dreq_route_t rq;
  assign rq = pin_q.dreq_rt;
  wire logic full_dx  = rq.full_duplex;                                     // R8
  // Half duplex: one request source only, never both directions
  wire logic half_src = rq.b_half ? pin_q.req_b : pin_q.req_a;              // R9 R10
  wire logic drq3_d   = full_dx ? (rq.d3_a_only ? pin_q.req_a : pin_q.dtr_req_a) :
                        rq.d3_a_only ? pin_q.req_a :
                        rq.d3_a_or_b ? half_src : 1'b0;                     // R8 R10
  wire logic drq1_d   = full_dx ? (rq.d1_a_only ? pin_q.req_a : pin_q.dtr_req_a) :
                        rq.d1_a_only ? pin_q.req_a :
                        rq.d1_a_or_b ? half_src : 1'b0;                     // R8 R10
  // Jumper 7 wins outright; software bit counts only with jumper 8
  wire logic drv_en   = rq.perm_enable || (rq.sw_enable && dma_en_q);      // R12 R14

  //////////////////////////////////////////////////////////////////////////
  // DMA acknowledge routing, acknowledges gated by the driver enable
  iscg_dack_route_t ak;
  assign ak = pin_q.dack_rt;
  wire logic ack1    = drv_en && !pin_q.dack1_n;
  wire logic ack3    = drv_en && !pin_q.dack3_n;
  wire logic ack_one = ak.both_ack ? (ack1 || ack3) :
                       ak.single_d3 ? ack3 :
                       ak.single_d1 ? ack1 : 1'b0;
  wire logic dack_a  = ak.chan_a_dma3_chan_b_dma1 ? ack3 :
                       ak.chan_a_dma1_chan_b_dma3 ? ack1 :
                       ak.a_only ? ack_one : 1'b0;                          // R11
  wire logic dack_b  = ak.chan_a_dma3_chan_b_dma1 ? ack1 :
                       ak.chan_a_dma1_chan_b_dma3 ? ack3 :
                       !ak.a_only ? ack_one : 1'b0;                         // R11

  //////////////////////////////////////////////////////////////////////////
  // Output flops; every pin leaves straight from a register
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ctl_cs_n     <= 1'b1;
      ctl_port     <= 2'h0;
      ctl_rd_n     <= 1'b1;
      ctl_wr_n     <= 1'b1;
      data_out     <= 8'h00;
      data_oe      <= 1'b0;
      irq_out      <= 4'h0;
      irq_oe       <= 4'h0;
      irq_pulldown <= 1'b0;
      drq1_out     <= 1'b0;
      drq3_out     <= 1'b0;
      drq_oe       <= 1'b0;
      dack_a_n     <= 1'b1;
      dack_b_n     <= 1'b1;
    end else begin
      ctl_cs_n     <= !(ctl_sel && (rd_act || wr_act));                     // R17
      ctl_port     <= offset[1:0];                                          // R4
      ctl_rd_n     <= !(ctl_sel && rd_act);
      ctl_wr_n     <= !(ctl_sel && wr_act);
      data_out     <= rd_port ? rd_data : 8'h00;
      data_oe      <= rd_port;                                              // R5
      irq_out      <= irq_out_d;
      irq_oe       <= irq_oe_d;                                             // R6
      irq_pulldown <= one_line && mode_shr;                                 // R7
      drq1_out     <= drv_en && drq1_d;
      drq3_out     <= drv_en && drq3_d;
      drq_oe       <= drv_en;                                               // R12
      dack_a_n     <= !dack_a;
      dack_b_n     <= !dack_b;
    end
  end

  // Terminal-ready pins mirror the port bits held above
  assign term_rdy_a = term_rdy_q[0];
  assign term_rdy_b = term_rdy_q[1];

  //////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  chk_cs_block_only: assert property (                                     // R17
    !ctl_cs_n |-> $past(blk_hit) && ($past(offset) <= `ISCG_OFF_B_CTRL))
    else $error("controller select outside offsets 0 to 3");
  chk_cs_port_excl: assert property (                                      // R5
    !(!ctl_cs_n && data_oe))
    else $error("controller and board port selected together");
  chk_base_match: assert property (                                        // R3
    data_oe |-> $past(pin_q.addr[9:3]) == $past(pin_q.base_sw))
    else $error("board port answered a foreign address");
  chk_port_write: assert property (                                        // R16
    port_wr ##1 1'b1 |-> term_rdy_a == $past(pin_q.data[0], 1) &&
                         dma_en_q == $past(pin_q.data[7], 1))
    else $error("board port write not taken");
  chk_read_dsr: assert property (                                          // R16
    data_oe |-> data_out == {6'h00, $past(pin_q.dsr)})
    else $error("board port read value wrong");
  chk_dma_reset: assert property (disable iff (1'b0)                       // R13
    !reset_n ##1 1'b1 |-> !dma_en_q)
    else $error("dma enable survived reset");
  chk_perm_enable: assert property (                                       // R14
    rq.perm_enable |=> drq_oe)
    else $error("permanent dma enable not honoured");
  chk_no_jumper: assert property (                                         // R12
    !rq.perm_enable && !rq.sw_enable |=> !drq_oe && !drq1_out && !drq3_out)
    else $error("dma drivers active with no enable jumper");
  chk_irq_single: assert property (                                        // R6
    irq_oe != 4'h0 |-> $onehot0(irq_oe) && $past(one_line))
    else $error("interrupt on more than one line");
  chk_shared_drive: assert property (                                      // R7
    one_line && mode_shr && !pin_q.ctl_int |=> irq_oe == 4'h0 && irq_pulldown)
    else $error("shared line driven while idle");
  chk_half_single: assert property (                                       // R9
    !rq.full_duplex && !rq.b_half && !pin_q.req_a |=> !drq1_out && !drq3_out)
    else $error("half duplex request without source");
  chk_ack_split: assert property (                                         // R11
    ak.chan_a_dma3_chan_b_dma1 && drv_en && !pin_q.dack3_n |=> !dack_a_n)
    else $error("split acknowledge not routed");

  // Decode, interrupt, DMA routing and port reset; all but chk_strobe_cs and chk_gate_off look one edge past their cause
  chk_aen_quiet: assert property (                                         // R1
    pin_q.aen |=> ctl_cs_n && !data_oe)
    else $error("decode active during a dma cycle");
  chk_base_range: assert property (                                        // R2
    !base_ok |=> ctl_cs_n && !data_oe)
    else $error("card answered with base switch out of range");
  chk_port_offset: assert property (                                       // R4
    !ctl_cs_n |-> ctl_port == $past(offset[1:0]))
    else $error("controller port does not follow offset");
  chk_strobe_cs: assert property (                                         // R17
    (!ctl_wr_n || !ctl_rd_n) |-> !ctl_cs_n)
    else $error("controller strobe without chip select");
  chk_offset_quiet: assert property (                                      // R17
    blk_hit && (offset > `ISCG_OFF_CTRL_STATUS) |=> ctl_cs_n && !data_oe)
    else $error("card answered offsets five to seven");
  chk_no_route: assert property (                                          // R6
    !one_line |=> irq_oe == 4'h0 && !irq_pulldown)
    else $error("interrupt driven with no single line jumper");
  chk_dedicated_drive: assert property (                                   // R7
    one_line && mode_ded |=> irq_oe == $past(line_j) && !irq_pulldown)
    else $error("dedicated line not driven alone");
  chk_shared_pull: assert property (                                       // R7
    one_line && mode_shr && pin_q.ctl_int |=> irq_oe == $past(line_j) && irq_out == $past(line_j))
    else $error("shared line not pulled high on request");
  chk_full_both: assert property (                                         // R8
    drv_en && rq.full_duplex && pin_q.req_a && pin_q.dtr_req_a |=> drq1_out && drq3_out)
    else $error("full duplex does not use both dma channels");
  chk_half_b_src: assert property (                                        // R10
    drv_en && !rq.full_duplex && rq.b_half && rq.d1_a_or_b && !rq.d1_a_only
    |=> drq1_out == $past(pin_q.req_b))
    else $error("channel B half duplex request not routed");
  chk_split_b: assert property (                                           // R11
    ak.chan_a_dma3_chan_b_dma1 && drv_en && !pin_q.dack1_n |=> !dack_b_n)
    else $error("split acknowledge for channel B not routed");
  chk_single_a: assert property (                                          // R11
    !ak.chan_a_dma3_chan_b_dma1 && !ak.chan_a_dma1_chan_b_dma3 && ak.a_only |=> dack_b_n)
    else $error("channel B acknowledged in channel A only mode");
  chk_sw_off: assert property (                                            // R12
    rq.sw_enable && !rq.perm_enable && !dma_en_q |=> !drq_oe)
    else $error("dma drivers on with software enable clear");
  chk_gate_off: assert property (                                          // R12
    !drq_oe |-> !drq1_out && !drq3_out && dack_a_n && dack_b_n)
    else $error("dma lines active with drivers off");
  chk_port_reset: assert property (disable iff (1'b0)                      // R13
    !reset_n |=> !term_rdy_a && !term_rdy_b)
    else $error("terminal ready survived reset");

  cov_port_write: cover property (port_wr ##[1:20] data_oe);
  cov_full_duplex: cover property (drq1_out && drq3_out && $past(rq.full_duplex));
  cov_shared_irq: cover property (irq_pulldown && irq_oe != 4'h0);
  cov_ctl_access: cover property (!ctl_cs_n ##1 ctl_cs_n);
  cov_dma_ack: cover property (!dack_a_n ##1 dack_a_n);
endmodule

/* File: bench/iscg_host_model.sv */
// Host expansion bus model: drives address, strobes, address enable and write data.
// Assumes the bench supplies straps and the DMA and status lines through the side bundle.
`timescale 1ns/1ns

module iscg_host_model (
  input  wire logic                 clk,
  input  wire iscg_pkg::iscg_pins_t side,
  output iscg_pkg::iscg_pins_t      pins
);
  import iscg_pkg::*;

  logic [9:0] addr_q;
  logic [7:0] data_q;
  logic       ior_n_q, iow_n_q, aen_q;

  ////////////////////////////////////////////////////////////////////////////
  // Bus fields overlay the bench side; address is held with the strobe
  always_comb begin
    pins       = side;
    pins.addr  = addr_q;
    pins.data  = data_q;
    pins.ior_n = ior_n_q;
    pins.iow_n = iow_n_q;
    pins.aen   = aen_q;
  end

  initial begin
    addr_q  = 10'h000;
    data_q  = 8'h00;
    ior_n_q = 1'b1;
    iow_n_q = 1'b1;
    aen_q   = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Open a cycle just after an edge; address, data and strobe all change together
  task automatic start(input logic [9:0] a, input logic wr, input logic [7:0] d,
                       input logic dma);
    @(posedge clk);
    addr_q <= a;
    data_q <= d;
    aen_q  <= dma;
    if (wr) begin
      iow_n_q <= 1'b0;
    end else begin
      ior_n_q <= 1'b0;
    end
  endtask

  // Released bus shows the inverse, so a stale value can never look valid
  task automatic stop();
    @(posedge clk);
    ior_n_q <= 1'b1;
    iow_n_q <= 1'b1;
    aen_q   <= 1'b0;
    addr_q  <= ~addr_q;
    data_q  <= ~data_q;
  endtask
endmodule

/* File: bench/isa_serial_card_host_glue_bench.sv */
// Self-checking bench for the serial card host glue.
// Assumes a fixed three-cycle pin-to-output latency and idle strobes between accesses.
`timescale 1ns/1ns
`include "iscg_defs.svh"
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin err_count++; \
  $display("mismatch t=%0t got=%0h exp=%0h", $time, (got), (exp)); end end

module isa_serial_card_host_glue_bench;
  import iscg_pkg::*;

  logic       clk, reset_n, ctl_cs_n, ctl_rd_n, ctl_wr_n, data_oe, irq_pulldown;
  logic       drq1_out, drq3_out, drq_oe, dack_a_n, dack_b_n, term_rdy_a, term_rdy_b;
  logic [1:0] ctl_port;
  logic [7:0] data_out;
  logic [3:0] irq_out, irq_oe, line, exp_oe;
  logic [6:0] sw_tab [6];
  logic [9:0] ad_tab [6];
  logic [1:0] ms_tab [6];
  logic [22:0] dma_tab [16];
  iscg_pins_t side, pins, cfg;
  int         err_count, checks_done;

  iscg_glue u_iscg_glue (.clk(clk), .reset_n(reset_n), .pins(pins), .ctl_cs_n(ctl_cs_n),
    .ctl_port(ctl_port), .ctl_rd_n(ctl_rd_n), .ctl_wr_n(ctl_wr_n), .data_out(data_out),
    .data_oe(data_oe), .irq_out(irq_out), .irq_oe(irq_oe), .irq_pulldown(irq_pulldown),
    .drq1_out(drq1_out), .drq3_out(drq3_out), .drq_oe(drq_oe), .dack_a_n(dack_a_n),
    .dack_b_n(dack_b_n), .term_rdy_a(term_rdy_a), .term_rdy_b(term_rdy_b));
  iscg_host_model u_iscg_host_model (.clk(clk), .side(side), .pins(pins));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Helpers: fixed waits follow the three-cycle latency, plus one to settle
  task automatic results();
    $display("checks_done=%0d err_count=%0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic apply();
    @(posedge clk);
    side <= cfg;
    tick(4);
  endtask
  task automatic access(input logic [9:0] a, input logic wr, input logic [7:0] d,
                        input logic dma);
    u_iscg_host_model.start(a, wr, d, dma);
    tick(4);
  endtask
  task automatic done_access();
    u_iscg_host_model.stop();
    tick(4);
  endtask
  task automatic pulse_reset();
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    tick(3);
  endtask

  // Watchdog cuts a hang short
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    results();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    err_count = 0;
    checks_done = 0;
    reset_n = 1'b0;
    cfg = '0;
    cfg.dack1_n = 1'b1;
    cfg.dack3_n = 1'b1;
    cfg.dsr = 2'h2;
    cfg.base_sw = `ISCG_DEF_BASE_SW;  // Factory base 238h
    side = cfg;
    sw_tab = '{7'h47, 7'h47, 7'h1F, 7'h20, 7'h7F, 7'h55};
    ad_tab = '{10'h240, 10'h238, 10'h0F8, 10'h100, 10'h3F8, 10'h2A8};
    ms_tab = '{2'b01, 2'b11, 2'b01, 2'b00, 2'b00, 2'b00};  // {aen, miss}
    // {dreq, dack route, req_a, dtr_req_a, req_b, dack1_n, dack3_n, drq1, drq3, a_n, b_n}
    dma_tab = '{{8'h69, 6'h00, 5'b10011, 4'b1011}, {8'h69, 6'h00, 5'b01011, 4'b0111},
                {8'h54, 6'h00, 5'b00111, 4'b1011}, {8'h58, 6'h00, 5'b00111, 4'b0011},
                {8'h58, 6'h00, 5'b10011, 4'b1011}, {8'h29, 6'h00, 5'b10011, 4'b0011},
                {8'h40, 6'h02, 5'b00010, 4'b0001}, {8'h40, 6'h02, 5'b00001, 4'b0010},
                {8'h40, 6'h04, 5'b00001, 4'b0001}, {8'h40, 6'h04, 5'b00010, 4'b0010},
                {8'h40, 6'h28, 5'b00001, 4'b0001}, {8'h40, 6'h20, 5'b00001, 4'b0010},
                {8'h40, 6'h10, 5'b00010, 4'b0010}, {8'h40, 6'h09, 5'b00010, 4'b0001},
                {8'h00, 6'h02, 5'b00010, 4'b0011}, {8'h69, 6'h00, 5'b11011, 4'b1111}};
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    tick(3);
    `CHK({ctl_cs_n, data_oe, drq_oe, term_rdy_a, term_rdy_b}, 5'h10)
    // Every offset of the block at the factory base
    for (int k = 0; k < 8; k++) begin
      access(10'h238 + 10'(k), 1'b0, 8'h00, 1'b0);
      `CHK({ctl_cs_n, ctl_rd_n}, {2{k > 3}})
      `CHK(data_oe, k == 4)
      if (k < 4) `CHK(ctl_port, 2'(k))
      if (k == 4) `CHK(data_out, 8'h02)
      done_access();
    end
    access(10'h239, 1'b1, 8'h5A, 1'b0);
    `CHK({ctl_cs_n, ctl_wr_n, ctl_rd_n, ctl_port}, 5'b00101)
    done_access();
    // Switch polarity, base range and address enable
    for (int k = 0; k < 6; k++) begin
      cfg.base_sw = sw_tab[k];
      apply();
      access(ad_tab[k], 1'b0, 8'h00, ms_tab[k][1]);
      `CHK(ctl_cs_n, ms_tab[k][0])
      done_access();
    end
    // DMA driver gating by jumper and port bit
    cfg.base_sw = 7'h47;
    cfg.dreq_rt = iscg_dreq_route_t'(8'h80);
    apply();
    access(10'h23C, 1'b1, 8'h83, 1'b0);
    `CHK({term_rdy_b, term_rdy_a, drq_oe}, 3'b111)
    done_access();
    access(10'h23C, 1'b1, 8'h00, 1'b0);
    `CHK({term_rdy_b, term_rdy_a, drq_oe}, 3'b000)
    done_access();
    cfg.dreq_rt = iscg_dreq_route_t'(8'h40);
    apply();
    `CHK(drq_oe, 1'b1)
    cfg.dreq_rt = iscg_dreq_route_t'(8'h00);
    apply();
    `CHK(drq_oe, 1'b0)
    cfg.dreq_rt = iscg_dreq_route_t'(8'h80);
    apply();
    access(10'h23C, 1'b1, 8'h80, 1'b0);
    done_access();
    `CHK(drq_oe, 1'b1)
    pulse_reset();
    `CHK(drq_oe, 1'b0)
    // Request and acknowledge routing
    for (int k = 0; k < 16; k++) begin
      cfg.dreq_rt = iscg_dreq_route_t'(dma_tab[k][22:15]);
      cfg.dack_rt = iscg_dack_route_t'(dma_tab[k][14:9]);
      {cfg.req_a, cfg.dtr_req_a, cfg.req_b, cfg.dack1_n, cfg.dack3_n} = dma_tab[k][8:4];
      apply();
      `CHK({drq1_out, drq3_out, dack_a_n, dack_b_n}, dma_tab[k][3:0])
    end
    // Interrupt line, mode and request level
    for (int k = 0; k < 20; k++) begin
      line = (k < 16) ? 4'h1 << (k / 4) : 4'h3;
      cfg.irq_rt = {k[1], ~k[1], line};
      cfg.ctl_int = k[0];
      apply();
      exp_oe = (k >= 16) ? 4'h0 : ((k[1] && !k[0]) ? 4'h0 : line);
      `CHK({irq_oe, irq_out & exp_oe}, {exp_oe, k[0] ? exp_oe : 4'h0})
      `CHK(irq_pulldown, k[1] && (k < 16))
    end
    cfg.irq_rt = {2'b00, 4'h8};
    apply();
    `CHK(irq_oe, 4'h0)
    // Factory DMA straps: receive request on DMA 3, acknowledge to channel A
    cfg.dreq_rt = iscg_dreq_route_t'(`ISCG_DEF_DREQ_ROUTE);
    cfg.dack_rt = iscg_dack_route_t'(`ISCG_DEF_DACK_ROUTE);
    {cfg.req_a, cfg.dtr_req_a, cfg.dack1_n, cfg.dack3_n} = 4'b1010;
    apply();
    access(10'h23C, 1'b1, 8'h80, 1'b0);
    `CHK({drq1_out, drq3_out, drq_oe, dack_a_n, dack_b_n}, 5'b01101)
    done_access();
    results();
  end
endmodule
